//--- pkg/dwe_defines.svh
// Register map, field positions, codes and timing figures of the warning encoder
`ifndef DWE_DEFINES_SVH
`define DWE_DEFINES_SVH

// Clock rate and documented times
`define DWE_CLK_HZ          100000000
`define DWE_SAFETY_LAG_S    10
`define DWE_OPEN_PHASE_S    1

// Position data limit and percent divisor
`define DWE_POS_LIMIT       32'sh7000_0000
`define DWE_PCT_DIV         40'h00_0000_0064

// Register byte offsets
`define DWE_OFS_CTRL        6'h00
`define DWE_OFS_EXCESS_LVL  6'h04
`define DWE_OFS_ERR_PCT     6'h08
`define DWE_OFS_SON_LVL     6'h0C
`define DWE_OFS_SON_PCT     6'h10
`define DWE_OFS_IRQ_STAT    6'h14
`define DWE_OFS_IRQ_MASK    6'h18
`define DWE_OFS_ALARM       6'h1C
`define DWE_OFS_WARN        6'h20

// Control register field positions
`define DWE_CTRL_CODE_OUT   0
`define DWE_CTRL_WARN_DIS   1
`define DWE_CTRL_SUPPLY     2
`define DWE_CTRL_VIB_SEL    3

// Warning index, lowest warning number first
`define DWE_W_POS_ERR       0
`define DWE_W_SON_ERR       1
`define DWE_W_OVERLOAD      2
`define DWE_W_VIBRATION     3
`define DWE_W_REGEN         4
`define DWE_W_DBRAKE        5
`define DWE_W_RESTART       6
`define DWE_W_UNDERVOLT     7
`define DWE_W_OVERTRAVEL    8
`define DWE_NUM_WARN        9

// Alarm and interrupt bit positions
`define DWE_A_POS_DATA      0
`define DWE_A_SAFETY        1
`define DWE_A_OPEN_PHASE    2
`define DWE_A_VIBRATION     3
`define DWE_I_WARN_NEW      4
`define DWE_NUM_EVT         5

// Codes on lines one, two, three (bit 2 is line one)
`define DWE_CODE_HHH        3'h7
`define DWE_CODE_LHH        3'h3
`define DWE_CODE_HLH        3'h5
`define DWE_CODE_HHL        3'h6
`define DWE_CODE_LLL        3'h0
`define DWE_CODE_HLL        3'h4
`define DWE_CODE_IDLE       3'h0

// Reset values
`define DWE_RST_CTRL        4'h0
`define DWE_RST_LVL         32'h0000_0000
`define DWE_RST_PCT         8'h64

`endif

//--- pkg/dwe_pkg.sv
// Types shared by the warning encoder and its bench
package dwe_pkg;

  typedef struct packed {
    logic vib_alarm_sel;
    logic single_phase;
    logic warn_disable;
    logic code_out_en;
  } dwe_ctrl_t;

  typedef struct packed {
    logic overload_pre;
    logic vibration;
    logic regen_pre;
    logic dbrake_pre;
    logic restart_changed;
    logic undervolt_pre;
    logic overtravel;
  } dwe_cond_t;

  typedef struct packed {
    logic code_line_one;
    logic code_line_two;
    logic code_line_three;
  } dwe_code_t;

endpackage

//--- hdl/dwe_top.sv
// Servo drive fault detection and warning code encoder with Avalon-MM registers
//
// What this block does
// - Alarm when position data exceeds 1879048192 magnitude
// - Alarm when safety inputs lag ten seconds
// - Open phase alarm: phase low over 1 s while main supply is on
// - Single-phase setting suppresses open phase alarm
// - Position error warning above level*percent/100, HHH
// - Servo-on error warning while powered, code HHH
// - Overload pre-warning, code LHH
// - Vibration gives alarm or warning by select, LHH
// - Regenerative and brake pre-warnings, code HLH
// - Restart-required warning, code HHL
// - Undervoltage pre-warning, code LLL
// - Overtravel while powered warning, code HLL
// - Codes shown only when code output select set
// - Detect disable masks all warnings but undervoltage
`include "dwe_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module dwe_top #(
  parameter int SAFETY_LAG_CYC = `DWE_SAFETY_LAG_S * `DWE_CLK_HZ,
  parameter int OPEN_PHASE_CYC = `DWE_OPEN_PHASE_S * `DWE_CLK_HZ,
  parameter int CNT_W          = 30
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // Avalon-MM slave
  input  wire logic [5:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  // Motion and power state from drive logic
  input  wire logic signed [31:0] position_data,
  input  wire logic [31:0]       position_error,
  input  wire logic              motor_power_on,
  input  wire logic              main_supply_on,
  input  wire dwe_pkg::dwe_cond_t cond,
  // Pins from outside the clock domain
  input  wire logic              safety_block_in_a_n,
  input  wire logic              safety_block_in_b_n,
  input  wire logic [2:0]        phase_low,
  // Code lines and alarms
  output dwe_pkg::dwe_code_t     code_lines,
  output logic                   code_valid,
  output logic [3:0]             alarm,
  output logic                   irq
);

  generate
    if (SAFETY_LAG_CYC < 1 || OPEN_PHASE_CYC < 1 ||
        SAFETY_LAG_CYC >= (1 << CNT_W) || OPEN_PHASE_CYC >= (1 << CNT_W)) begin : g_bad
      $error("dwe_top: timing counts do not fit the counter");
    end
    // Width above 31 would overflow the int shift in the check above
    if (CNT_W < 2 || CNT_W > 31) begin : g_bad_w
      $error("dwe_top: counter width out of range");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Level times percent over 100, 40 bits to keep the product whole
  function automatic logic [39:0] scaled(input logic [31:0] lvl,
                                         input logic [7:0]  pct);
    logic [39:0] p;
    p = {8'h00, lvl} * {32'h0000_0000, pct};
    return p / `DWE_PCT_DIV;
  endfunction

  // Idle shares 000 with undervoltage; code_valid tells them apart
  function automatic logic [2:0] warn_code(input logic [3:0] idx);
    logic [2:0] c;
    case (idx)
      4'h0, 4'h1: c = `DWE_CODE_HHH;
      4'h2, 4'h3: c = `DWE_CODE_LHH;
      4'h4, 4'h5: c = `DWE_CODE_HLH;
      4'h6:       c = `DWE_CODE_HHL;
      4'h7:       c = `DWE_CODE_LLL;
      4'h8:       c = `DWE_CODE_HLL;
      default:    c = `DWE_CODE_IDLE;
    endcase
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, change accepted when last two agree

  // Only stage two reads stage one; stage one may be metastable
  localparam int NSYNC = 5;
  logic [NSYNC-1:0] s1_q, s2_q, s3_q, pin_q;
  logic [NSYNC-1:0] pin_raw;
  assign pin_raw = {phase_low, ~safety_block_in_b_n, ~safety_block_in_a_n};

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      pin_q <= '0;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < NSYNC; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          pin_q[i] <= s3_q[i];
        end
      end
    end
  end

  wire logic       safe_a_act = pin_q[0];
  wire logic       safe_b_act = pin_q[1];
  wire logic [2:0] phase_lo   = pin_q[4:2];

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  dwe_pkg::dwe_ctrl_t ctrl_q;
  logic [31:0] excess_lvl_q, son_lvl_q;
  logic [7:0]  err_pct_q, son_pct_q;
  logic [`DWE_NUM_EVT-1:0] irq_stat_q, irq_mask_q;
  logic [3:0]  alarm_q;
  logic [`DWE_NUM_WARN-1:0] warn_q;

  // Bus handshake: one wait cycle, then the access completes
  logic        wait_q;
  logic [31:0] rdata_q;
  wire logic   req     = avs_read | avs_write;
  wire logic   acc     = req & ~wait_q;
  wire logic   wr_acc  = acc & avs_write;
  wire logic   rd_acc  = acc & avs_read;
  wire logic [31:0] ctrl_word = {28'h000_0000, ctrl_q};
  wire logic [31:0] wmerge_ctrl = merge_be(ctrl_word, avs_writedata, avs_byteenable);

  function automatic logic wr_hit(input logic [5:0] ofs);
    return wr_acc && (avs_address == ofs);
  endfunction

  logic [31:0] rd_mux;
  always_comb begin
    case (avs_address)
      `DWE_OFS_CTRL:       rd_mux = ctrl_word;
      `DWE_OFS_EXCESS_LVL: rd_mux = excess_lvl_q;
      `DWE_OFS_ERR_PCT:    rd_mux = {24'h00_0000, err_pct_q};
      `DWE_OFS_SON_LVL:    rd_mux = son_lvl_q;
      `DWE_OFS_SON_PCT:    rd_mux = {24'h00_0000, son_pct_q};
      `DWE_OFS_IRQ_STAT:   rd_mux = {27'h000_0000, irq_stat_q};
      `DWE_OFS_IRQ_MASK:   rd_mux = {27'h000_0000, irq_mask_q};
      `DWE_OFS_ALARM:      rd_mux = {28'h000_0000, alarm_q};
      `DWE_OFS_WARN:       rd_mux = {23'h00_0000, warn_q};
      default:             rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      // Read data taken in the wait cycle so it stands when waitrequest drops
      wait_q <= ~(req & wait_q);
      if (req & wait_q) begin
        rdata_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_q       <= `DWE_RST_CTRL;
      excess_lvl_q <= `DWE_RST_LVL;
      son_lvl_q    <= `DWE_RST_LVL;
      err_pct_q    <= `DWE_RST_PCT;
      son_pct_q    <= `DWE_RST_PCT;
      irq_mask_q   <= '0;
    end else begin
      if (wr_hit(`DWE_OFS_CTRL)) ctrl_q <= wmerge_ctrl[3:0];
      if (wr_hit(`DWE_OFS_EXCESS_LVL))
        excess_lvl_q <= merge_be(excess_lvl_q, avs_writedata, avs_byteenable);
      if (wr_hit(`DWE_OFS_SON_LVL))
        son_lvl_q <= merge_be(son_lvl_q, avs_writedata, avs_byteenable);
      if (wr_hit(`DWE_OFS_ERR_PCT) && avs_byteenable[0]) err_pct_q <= avs_writedata[7:0];
      if (wr_hit(`DWE_OFS_SON_PCT) && avs_byteenable[0]) son_pct_q <= avs_writedata[7:0];
      if (wr_hit(`DWE_OFS_IRQ_MASK) && avs_byteenable[0])
        irq_mask_q <= avs_writedata[`DWE_NUM_EVT-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alarms

  // Signed compare; the limit value itself is still legal
  wire logic pos_ovf = (position_data > `DWE_POS_LIMIT) ||
                       (position_data < -`DWE_POS_LIMIT);

  // Safety inputs: count while exactly one of the pair is active
  // Holds at the limit, so a clear only sticks once the pair agrees
  logic [CNT_W-1:0] lag_cnt_q;
  wire logic one_only = safe_a_act ^ safe_b_act;
  wire logic lag_hit  = one_only && (lag_cnt_q == CNT_W'(SAFETY_LAG_CYC - 1));

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lag_cnt_q <= '0;
    end else if (!one_only) begin
      lag_cnt_q <= '0;
    end else if (!lag_hit) begin
      lag_cnt_q <= lag_cnt_q + 1'b1;
    end
  end

  // Open phase: single-phase setting means a dead phase is expected
  // Same hold: the alarm clears only after the phase recovers
  logic [CNT_W-1:0] ph_cnt_q;
  wire logic ph_watch = main_supply_on && (|phase_lo) && !ctrl_q.single_phase;
  wire logic ph_hit   = ph_watch && (ph_cnt_q == CNT_W'(OPEN_PHASE_CYC));

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ph_cnt_q <= '0;
    end else if (!ph_watch) begin
      ph_cnt_q <= '0;
    end else if (!ph_hit) begin
      ph_cnt_q <= ph_cnt_q + 1'b1;
    end
  end

  wire logic vib_alarm = cond.vibration && ctrl_q.vib_alarm_sel;

  wire logic [3:0] alarm_set = {vib_alarm, ph_hit, lag_hit, pos_ovf};
  // Decoded inline: a continuous assign would miss a function's hidden inputs
  wire logic alarm_wr = wr_acc && (avs_address == `DWE_OFS_ALARM) && avs_byteenable[0];
  wire logic [3:0] alarm_clr = alarm_wr ? avs_writedata[3:0] : 4'h0;

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      alarm_q <= 4'h0;
    end else begin
      alarm_q <= (alarm_q & ~alarm_clr) | alarm_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Warnings

  wire logic [39:0] err_lim = scaled(excess_lvl_q, err_pct_q);
  wire logic [39:0] son_lim = scaled(son_lvl_q, son_pct_q);
  wire logic [39:0] err_ext = {8'h00, position_error};

  logic [`DWE_NUM_WARN-1:0] warn_raw;
  assign warn_raw[`DWE_W_POS_ERR]    = err_ext > err_lim;
  assign warn_raw[`DWE_W_SON_ERR]    = motor_power_on && (err_ext > son_lim);
  assign warn_raw[`DWE_W_OVERLOAD]   = cond.overload_pre;
  assign warn_raw[`DWE_W_VIBRATION]  = cond.vibration && !ctrl_q.vib_alarm_sel;
  assign warn_raw[`DWE_W_REGEN]      = cond.regen_pre;
  assign warn_raw[`DWE_W_DBRAKE]     = cond.dbrake_pre;
  assign warn_raw[`DWE_W_RESTART]    = cond.restart_changed;
  assign warn_raw[`DWE_W_UNDERVOLT]  = cond.undervolt_pre;
  assign warn_raw[`DWE_W_OVERTRAVEL] = cond.overtravel && motor_power_on;

  // Undervoltage stays visible even with detection disabled
  logic [`DWE_NUM_WARN-1:0] keep_mask;
  assign keep_mask = ctrl_q.warn_disable ?
                     (`DWE_NUM_WARN'(1) << `DWE_W_UNDERVOLT) : '1;
  wire logic [`DWE_NUM_WARN-1:0] warn_d = warn_raw & keep_mask;

  // Lowest index first
  logic [3:0] win_idx;
  always_comb begin
    win_idx = 4'hF;
    for (int i = `DWE_NUM_WARN - 1; i >= 0; i--) begin
      if (warn_q[i]) begin
        win_idx = 4'(i);
      end
    end
  end

  // Registered so the lines never glitch while the winner changes
  wire logic any_warn = |warn_q;
  wire logic show     = any_warn && ctrl_q.code_out_en;
  wire logic [2:0] code_d = show ? warn_code(win_idx) : `DWE_CODE_IDLE;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      warn_q     <= '0;
      code_lines <= `DWE_CODE_IDLE;
      code_valid <= 1'b0;
    end else begin
      warn_q     <= warn_d;
      code_lines <= code_d;
      code_valid <= show;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: sticky status cleared by reading it

  // Irq built from the next status so it rises with the status bit
  wire logic warn_new = |(warn_d & ~warn_q);
  wire logic [`DWE_NUM_EVT-1:0] evt = {warn_new, alarm_set & ~alarm_q};
  wire logic stat_rd = rd_acc && (avs_address == `DWE_OFS_IRQ_STAT);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq_stat_q <= '0;
      irq        <= 1'b0;
    end else begin
      irq_stat_q <= (stat_rd ? '0 : irq_stat_q) | evt;
      irq        <= |(((stat_rd ? '0 : irq_stat_q) | evt) & irq_mask_q);
    end
  end

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign alarm           = alarm_q;

endmodule

`default_nettype wire

//--- sim/dwe_top_asserts.sv
// Concurrent checks on the warning encoder ports
`timescale 1ns/1ps
`default_nettype none
module dwe_top_asserts (
  // Clock and reset
  input wire logic               clk,
  input wire logic               rst_b,
  // Bus and drive state
  input wire logic               avs_read,
  input wire logic               avs_write,
  input wire logic               avs_waitrequest,
  input wire logic signed [31:0] position_data,
  input wire logic               motor_power_on,
  input wire dwe_pkg::dwe_cond_t cond,
  // Outputs
  input wire dwe_pkg::dwe_code_t code_lines,
  input wire logic               code_valid,
  input wire logic [3:0]         alarm
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire logic [2:0] code = code_lines;
  ////////////////////////////////////////
  // Codes stand two edges after their cause
  a_pos_ovf: assert property (
    (position_data > 32'sh7000_0000 || position_data < -32'sh7000_0000) |=> alarm[0])
    else $error("overflow alarm missing");
  a_load_code: assert property (
    code_valid && code == 3'h3 |-> $past(cond.overload_pre || cond.vibration, 2))
    else $error("LHH without cause");
  a_regen_code: assert property (
    code_valid && code == 3'h5 |-> $past(cond.regen_pre || cond.dbrake_pre, 2))
    else $error("HLH without cause");
  a_restart_code: assert property (
    code_valid && code == 3'h6 |-> $past(cond.restart_changed, 2))
    else $error("HHL without cause");
  a_uv_code: assert property (
    code_valid && code == 3'h0 |-> $past(cond.undervolt_pre, 2))
    else $error("LLL without cause");
  a_travel_code: assert property (
    code_valid && code == 3'h4 |-> $past(cond.overtravel && motor_power_on, 2))
    else $error("HLL without cause");
  a_idle_code: assert property (
    !code_valid |-> code == 3'h0)
    else $error("code lines not idle");
  a_prio_first: assert property (
    code_valid && $past(cond.overload_pre, 2) |-> code == 3'h3 || code == 3'h7)
    else $error("lower warning shown first");
  a_alarm_hold: assert property (
    alarm[1] && !avs_write |=> alarm[1])
    else $error("safety alarm dropped");
  a_bus_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no bus answer");
  cover property (code_valid && code == 3'h3);
  cover property (alarm[1]);
  cover property (avs_read && !avs_waitrequest);
endmodule
bind dwe_top dwe_top_asserts i_chk (.clk, .rst_b, .avs_read, .avs_write, .avs_waitrequest,
  .position_data, .motor_power_on, .cond, .code_lines, .code_valid, .alarm);
`default_nettype wire

//--- sim/dwe_host_model.sv
// Host model latching the warning code lines
`timescale 1ns/1ps
`default_nettype none
module dwe_host_model (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_b,
  // Code lines
  input  wire dwe_pkg::dwe_code_t code_lines,
  input  wire logic               code_valid,
  // Last code taken
  output var  logic [2:0]         host_code_q
);
  // Idle 000 equals undervoltage, so only flagged codes count
  always_ff @(posedge clk) begin
    if (!rst_b) host_code_q <= 3'h0;
    else if (code_valid) host_code_q <= code_lines;
  end
endmodule
`default_nettype wire

//--- sim/tb_top.sv
// Self-checking bench for the warning encoder
`include "dwe_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic               clk = 0, rst_b = 0, avs_read = 0, avs_write = 0;
  logic               motor_power_on = 0, main_supply_on = 0, irq, code_valid, avs_waitrequest;
  logic               safety_block_in_a_n = 1, safety_block_in_b_n = 1;
  logic [5:0]         avs_address = 6'h00;
  logic [31:0]        avs_writedata = 32'h0, position_error = 32'h0, avs_readdata, rdat;
  logic signed [31:0] position_data = 32'sh0;
  logic [2:0]         phase_low = 3'h0, host;
  logic [3:0]         alarm;
  dwe_pkg::dwe_cond_t cond = '0;
  dwe_pkg::dwe_code_t code_lines;
  int                 bad_count = 0, n_compared = 0;
  always #5 clk = ~clk;
  dwe_top #(.SAFETY_LAG_CYC(50), .OPEN_PHASE_CYC(30)) i_dut (.clk, .rst_b, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
    .avs_waitrequest, .position_data, .position_error, .motor_power_on, .main_supply_on,
    .cond, .safety_block_in_a_n, .safety_block_in_b_n, .phase_low, .code_lines,
    .code_valid, .alarm, .irq);
  dwe_host_model i_host (.clk, .rst_b, .code_lines, .code_valid, .host_code_q(host));
  ////////////////////////////////////////
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  // Request held until waitrequest is seen low
  task automatic bus(logic w, logic [5:0] a, logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    chk("bus_ready", 0, avs_waitrequest);
    rdat = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
    @(posedge clk);
  endtask
  task automatic code_is(string nm, logic [3:0] e);
    cyc(4);
    chk(nm, {28'h0, e}, {28'h0, code_valid, code_lines});
  endtask
  ////////////////////////////////////////
  task automatic t_regs;
    bus(0, `DWE_OFS_CTRL, 0);
    chk("ctrl", 0, rdat);
    bus(0, `DWE_OFS_ERR_PCT, 0);
    chk("pct", 32'h64, rdat);
    bus(0, 6'h3C, 0);
    chk("unmapped", 0, rdat);
    $display("t_regs done");
  endtask
  task automatic t_codes;
    logic [20:0] ec;
    ec = 21'h0DDB84;
    motor_power_on <= 1;
    bus(1, `DWE_OFS_CTRL, 1);
    for (int i = 0; i < 7; i++) begin
      cond <= 7'h01 << i;
      code_is("code", {1'b1, ec[3*i +: 3]});
    end
    cond <= 7'h01;
    motor_power_on <= 0;
    code_is("travel_off", 0);
    $display("t_codes done");
  endtask
  task automatic t_gate;
    bus(1, `DWE_OFS_CTRL, 0);
    cond <= 7'h02;
    code_is("hidden", 0);
    bus(1, `DWE_OFS_CTRL, 3);
    cond <= 7'h40;
    code_is("disabled", 0);
    cond <= 7'h02;
    code_is("uv_kept", 4'h8);
    $display("t_gate done");
  endtask
  task automatic t_prio;
    bus(1, `DWE_OFS_CTRL, 1);
    motor_power_on <= 1;
    cond <= 7'h41;
    code_is("prio", 4'hB);
    cond <= 0;
    code_is("idle", 0);
    chk("host", 3, host);
    $display("t_prio done");
  endtask
  task automatic t_poserr;
    motor_power_on <= 0;
    bus(1, `DWE_OFS_EXCESS_LVL, 32'h3E8);
    bus(1, `DWE_OFS_ERR_PCT, 32'h32);
    position_error <= 32'h1F4;
    code_is("at_limit", 0);
    position_error <= 32'h1F5;
    code_is("over", 4'hF);
    bus(1, `DWE_OFS_EXCESS_LVL, 32'hFFFF_FFFF);
    bus(1, `DWE_OFS_SON_LVL, 32'hC8);
    position_error <= 32'hC9;
    code_is("son_off", 0);
    motor_power_on <= 1;
    code_is("son_on", 4'hF);
    position_error <= 0;
    motor_power_on <= 0;
    $display("t_poserr done");
  endtask
  task automatic t_ovf;
    bus(0, `DWE_OFS_IRQ_STAT, 0);
    bus(1, `DWE_OFS_IRQ_MASK, 1);
    position_data <= 32'sh7000_0000;
    cyc(4);
    chk("limit", 0, alarm);
    position_data <= 32'sh7000_0001;
    cyc(4);
    chk("ovf", 1, alarm);
    chk("irq_set", 1, irq);
    position_data <= 0;
    bus(0, `DWE_OFS_IRQ_STAT, 0);
    chk("stat", 1, rdat);
    cyc(2);
    chk("irq_clr", 0, irq);
    bus(1, `DWE_OFS_ALARM, 1);
    chk("alarm_clr", 0, alarm);
    position_data <= -32'sh7000_0001;
    cyc(4);
    chk("neg_ovf", 1, alarm);
    position_data <= 0;
    bus(1, `DWE_OFS_ALARM, 1);
    $display("t_ovf done");
  endtask
  task automatic t_safety;
    safety_block_in_a_n <= 0;
    cyc(30);
    safety_block_in_b_n <= 0;
    cyc(10);
    chk("short_lag", 0, alarm);
    safety_block_in_a_n <= 1;
    safety_block_in_b_n <= 1;
    cyc(5);
    safety_block_in_a_n <= 0;
    cyc(70);
    chk("long_lag", 2, alarm);
    safety_block_in_a_n <= 1;
    cyc(6);
    bus(1, `DWE_OFS_ALARM, 2);
    chk("lag_clr", 0, alarm);
    $display("t_safety done");
  endtask
  task automatic t_phase;
    main_supply_on <= 1;
    phase_low <= 3'h2;
    cyc(20);
    phase_low <= 0;
    cyc(6);
    chk("short_dip", 0, alarm);
    phase_low <= 3'h2;
    cyc(45);
    chk("open", 4, alarm);
    phase_low <= 0;
    cyc(6);
    bus(1, `DWE_OFS_ALARM, 4);
    chk("open_clr", 0, alarm);
    bus(1, `DWE_OFS_CTRL, 5);
    phase_low <= 3'h2;
    cyc(45);
    chk("single", 0, alarm);
    phase_low <= 0;
    main_supply_on <= 0;
    bus(1, `DWE_OFS_CTRL, 9);
    cond <= 7'h20;
    code_is("vib_code", 0);
    chk("vib_alarm", 8, alarm);
    cond <= 0;
    $display("t_phase done");
  endtask
  task automatic test_done;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    cyc(5);
    rst_b <= 1;
    cyc(4);
    t_regs;
    t_codes;
    t_gate;
    t_prio;
    t_poserr;
    t_ovf;
    t_safety;
    t_phase;
    test_done;
  end
  // Whole run is about four hundred cycles
  initial begin
    cyc(5000);
    bad_count++;
    test_done;
  end
endmodule
`default_nettype wire
